// ==== src/rmc_pkg.sv ====
// Package for the miscellaneous radio configuration register bank.
// Assumes a byte-wide register port driven by the serial framing logic on the system clock.
package rmc_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_PWR_SAVE = 6'h2e;
    localparam logic [5:0] OFF_CARRIER_OVR = 6'h2f;
    localparam logic [5:0] OFF_CLK_MANUAL = 6'h32;
    localparam logic [5:0] OFF_CLK_GATE = 6'h33;
    localparam logic [5:0] OFF_SETTLE_CNT = 6'h38;
    localparam logic [5:0] OFF_ID_BYTE0 = 6'h3c;
    localparam logic [5:0] OFF_ID_BYTE1 = 6'h3d;
    localparam logic [5:0] OFF_ID_BYTE2 = 6'h3e;
    localparam logic [5:0] OFF_ID_BYTE3 = 6'h3f;
    localparam int CTRL_BIT = 7;
    localparam logic [7:0] RST_PWR_SAVE = 8'h00;
    localparam logic [7:0] RST_CARRIER_OVR = 8'h00;
    localparam logic [7:0] RST_CLK_MANUAL = 8'h00;
    localparam logic [7:0] RST_CLK_GATE = 8'h00;
    localparam logic [7:0] RST_SETTLE_CNT = 8'h64;
    localparam int ID_W = 30;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_STEP_NS = 2000;
    localparam int SETTLE_STEP_CYCLES = SETTLE_STEP_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        RMC_ST_IDLE = 2'b00,
        RMC_ST_WAIT = 2'b01,
        RMC_ST_LOCKED = 2'b11
    } rmc_lock_st_t;
endpackage

// ==== src/rmc_regs.sv ====
// Miscellaneous radio configuration register bank: power saving, carrier override,
// manual clock registers, synthesizer settle count and the read-only part identifier.
// Assumes the serial framing logic presents single-cycle read and write strobes on i_clk,
// and that the analog control bits arrive as levels from the same clock domain.
//
// Operation
// - A set power-saving bit switches off unused radio circuitry.
// - Power-saving writes take effect only while the analog write-enable bit is set.
// - The carrier override bit forces carrier detect and is writable only while write-enable is set.
// - In automatic synthesizer mode without the lock pin, lock is declared after count times 2 us.
// - The top two bits of the 32-bit identifier always read as zero.
// - The 30-bit identifier is visible only while the identifier read-enable bit is set.
// - The identifier bytes are read-only and writes leave them unchanged.
// - Identifier bytes map most to least significant onto 0x3f down to 0x3c.
`timescale 1ns/1ps
`default_nettype none
module rmc_regs #(
    parameter int STEP_CYCLES = rmc_pkg::SETTLE_STEP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_gate_wr_en,
    input wire logic i_id_rd_en,
    input wire logic [29:0] i_part_id,
    input wire logic i_synth_manual,
    input wire logic i_use_lock_pin,
    input wire logic i_synth_start,
    input wire logic i_pll_lock,
    output logic [7:0] o_rdata,
    output logic o_power_save,
    output logic o_carrier_override,
    output logic [7:0] o_clk_manual,
    output logic [7:0] o_clk_gate,
    output logic [7:0] o_settle_count,
    output logic o_id_powered,
    output logic o_synth_locked
);
    logic pll_meta_q;
    logic pll_sync_q;
    logic timed_mode;
    logic [31:0] id_word;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction

    assign timed_mode = !i_synth_manual && !i_use_lock_pin;
    // Identifier word: top two bits are hard zero, low bits gated by read-enable.
    assign id_word = {2'b00, i_id_rd_en ? i_part_id : 30'h00000000};

    ////////////////////////////////////////////////////////////////////////////
    // Gated control bits; reserved bits are not stored and read back as zero.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_power_save <= rmc_pkg::RST_PWR_SAVE[rmc_pkg::CTRL_BIT];
            o_carrier_override <= rmc_pkg::RST_CARRIER_OVR[rmc_pkg::CTRL_BIT];
        end
        else if (i_wr_stb && i_gate_wr_en)
        begin
            if (hit(i_addr, rmc_pkg::OFF_PWR_SAVE))
                o_power_save <= i_wdata[rmc_pkg::CTRL_BIT];
            if (hit(i_addr, rmc_pkg::OFF_CARRIER_OVR))
                o_carrier_override <= i_wdata[rmc_pkg::CTRL_BIT];
        end
    end

    // Clock registers stay at their reset value until the host loads them after each reset.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_clk_manual <= rmc_pkg::RST_CLK_MANUAL;
            o_clk_gate <= rmc_pkg::RST_CLK_GATE;
            o_settle_count <= rmc_pkg::RST_SETTLE_CNT;
        end
        else if (i_wr_stb)
        begin
            if (hit(i_addr, rmc_pkg::OFF_CLK_MANUAL))
                o_clk_manual <= i_wdata;
            if (hit(i_addr, rmc_pkg::OFF_CLK_GATE))
                o_clk_gate <= i_wdata;
            if (hit(i_addr, rmc_pkg::OFF_SETTLE_CNT))
                o_settle_count <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Identifier fuses draw power only while read-enable is on, so this output gates them.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_id_powered <= 1'b0;
        else
            o_id_powered <= i_id_rd_en;
    end

    // Read data is held until the next read strobe; unmapped offsets read zero.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_rdata <= 8'h00;
        else if (i_rd_stb)
        begin
            case (i_addr)
                rmc_pkg::OFF_PWR_SAVE: o_rdata <= {o_power_save, 7'h00};
                rmc_pkg::OFF_CARRIER_OVR: o_rdata <= {o_carrier_override, 7'h00};
                rmc_pkg::OFF_CLK_MANUAL: o_rdata <= o_clk_manual;
                rmc_pkg::OFF_CLK_GATE: o_rdata <= o_clk_gate;
                rmc_pkg::OFF_SETTLE_CNT: o_rdata <= o_settle_count;
                rmc_pkg::OFF_ID_BYTE0: o_rdata <= id_word[7:0];
                rmc_pkg::OFF_ID_BYTE1: o_rdata <= id_word[15:8];
                rmc_pkg::OFF_ID_BYTE2: o_rdata <= id_word[23:16];
                rmc_pkg::OFF_ID_BYTE3: o_rdata <= id_word[31:24];
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The lock pin is analog and asynchronous to the system clock.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            pll_meta_q <= 1'b0;
            pll_sync_q <= 1'b0;
        end
        else
        begin
            pll_meta_q <= i_pll_lock;
            pll_sync_q <= pll_meta_q;
        end
    end

    rmc_settle_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_settle (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_start(i_synth_start),
        .i_count(o_settle_count),
        .i_timed_mode(timed_mode),
        .i_pll_lock_s(pll_sync_q),
        .o_locked(o_synth_locked)
    );

    ////////////////////////////////////////////////////////////////////////////
    pwr_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && i_gate_wr_en && (i_addr == rmc_pkg::OFF_PWR_SAVE) |=> o_power_save == $past(i_wdata[7]))
        else $error("enabled power-saving write not stored");

    pwr_gated_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && !i_gate_wr_en && (i_addr == rmc_pkg::OFF_PWR_SAVE) |=> $stable(o_power_save))
        else $error("power-saving write accepted while disabled");

    carrier_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && (i_addr == rmc_pkg::OFF_CARRIER_OVR)
        |=> o_carrier_override == ($past(i_gate_wr_en) ? $past(i_wdata[7]) : $past(o_carrier_override)))
        else $error("carrier override write gating wrong");

    power_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(o_power_save) |-> $past(i_wr_stb && i_gate_wr_en && i_addr == rmc_pkg::OFF_PWR_SAVE))
        else $error("power saving set without an enabled write");

    id_top_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_rd_stb && (i_addr == rmc_pkg::OFF_ID_BYTE3) |=> o_rdata[7:6] == 2'b00)
        else $error("identifier top bits not zero");

    id_hidden_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_rd_stb && !i_id_rd_en && (i_addr[5:2] == 4'hf) |=> o_rdata == 8'h00)
        else $error("identifier visible without read-enable");

    id_bytes_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_rd_stb && i_id_rd_en && (i_addr == rmc_pkg::OFF_ID_BYTE2) |=> o_rdata == $past(i_part_id[23:16]))
        else $error("identifier byte order wrong");

    id_low_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_rd_stb && i_id_rd_en && (i_addr == rmc_pkg::OFF_ID_BYTE0) |=> o_rdata == $past(i_part_id[7:0]))
        else $error("identifier low byte misplaced");

    id_readonly_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && (i_addr[5:2] == 4'hf) |=> $stable(o_clk_manual) && $stable(o_settle_count)
        && $stable(o_power_save))
        else $error("write to identifier changed state");

    // Plain registers take every write; only the two control bits are gated.
    clk_manual_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && (i_addr == rmc_pkg::OFF_CLK_MANUAL) |=> o_clk_manual == $past(i_wdata))
        else $error("manual clock override write not stored");

    clk_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && (i_addr == rmc_pkg::OFF_CLK_GATE) |=> o_clk_gate == $past(i_wdata))
        else $error("manual clock gate write not stored");

    settle_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && (i_addr == rmc_pkg::OFF_SETTLE_CNT) |=> o_settle_count == $past(i_wdata))
        else $error("settle count write not stored");

    carrier_gated_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr_stb && !i_gate_wr_en && (i_addr == rmc_pkg::OFF_CARRIER_OVR) |=> $stable(o_carrier_override))
        else $error("carrier override write accepted while disabled");

    // The fuse power output lags read-enable by exactly one cycle.
    id_power_a: assert property (@(posedge i_clk) disable iff (i_srst)
        1'b1 |=> o_id_powered == $past(i_id_rd_en))
        else $error("identifier power does not follow read-enable");

    // Two synchroniser flops plus the output flop: lock follows the pin three cycles late.
    pin_lock_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !timed_mode && !$past(i_srst) && !$past(i_srst, 2)
        |=> o_synth_locked == $past(i_pll_lock, 3))
        else $error("lock output does not follow the synchronised pin");
endmodule
`default_nettype wire

// ==== src/rmc_settle_timer.sv ====
// Synthesizer settle timer: counts the settle value in fixed steps after a start pulse.
// Assumes the lock pin is already synchronised and start comes from logic on i_clk.
`timescale 1ns/1ps
`default_nettype none
module rmc_settle_timer #(
    parameter int STEP_CYCLES = rmc_pkg::SETTLE_STEP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [7:0] i_count,
    input wire logic i_timed_mode,
    input wire logic i_pll_lock_s,
    output logic o_locked
);
    rmc_pkg::rmc_lock_st_t state_q;
    logic [7:0] steps_q;
    logic [15:0] pre_q;
    logic step_tick;

    assign step_tick = (pre_q == 16'(STEP_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_q <= rmc_pkg::RMC_ST_IDLE;
            steps_q <= 8'h00;
            pre_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                rmc_pkg::RMC_ST_IDLE,
                rmc_pkg::RMC_ST_LOCKED:
                begin
                    if (i_start)
                    begin
                        state_q <= rmc_pkg::RMC_ST_WAIT;
                        steps_q <= i_count;
                        pre_q <= 16'h0000;
                    end
                end
                rmc_pkg::RMC_ST_WAIT:
                begin
                    // Each count is one full step; a count of zero locks at once.
                    if (steps_q == 8'h00)
                        state_q <= rmc_pkg::RMC_ST_LOCKED;
                    else if (step_tick)
                    begin
                        pre_q <= 16'h0000;
                        steps_q <= steps_q - 8'h01;
                    end
                    else
                        pre_q <= pre_q + 16'h0001;
                end
                default:
                    state_q <= rmc_pkg::RMC_ST_IDLE;
            endcase
        end
    end

    // Outside timed mode the lock pin decides, so the timer result is only used when timed.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_locked <= 1'b0;
        else if (i_timed_mode)
            o_locked <= (state_q == rmc_pkg::RMC_ST_LOCKED) && !i_start;
        else
            o_locked <= i_pll_lock_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    settle_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_start && i_timed_mode && (i_count != 8'h00) ##1 i_timed_mode [*8] |=> !o_locked)
        else $error("locked before settle delay elapsed");

    settle_done_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_start && i_timed_mode && (i_count == 8'h01) ##1 (!i_start && i_timed_mode) [*8]
        |-> ##[190:200] o_locked)
        else $error("one-step settle did not lock in time");
endmodule
`default_nettype wire

// ==== tb/rmc_host_model.sv ====
// Host controller model: drives the byte-wide register port and the analog control levels.
// Assumes the bank takes strobes on the rising clock edge and answers a read one cycle later.
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic o_wr_stb,
    output logic o_rd_stb,
    output logic [5:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_gate_wr_en,
    output logic o_id_rd_en
);
    initial
    begin
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
        o_addr = 6'h00;
        o_wdata = 8'h00;
        o_gate_wr_en = 1'b0;
        o_id_rd_en = 1'b0;
    end
    // Released lines show the inverse value so stale data is never mistaken for a live byte.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_wr_stb = 1'b1;
        o_addr = a;
        o_wdata = (a == rmc_pkg::OFF_PWR_SAVE || a == rmc_pkg::OFF_CARRIER_OVR) ? {d[7], 7'h00} : d;
        @(posedge i_clk);
        #1;
        o_wr_stb = 1'b0;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_rd_stb = 1'b1;
        o_addr = a;
        @(posedge i_clk);
        #1;
        o_rd_stb = 1'b0;
        o_addr = ~o_addr;
        d = i_rdata;
    endtask
    task automatic set_ctl(input logic gate, input logic id);
        @(posedge i_clk);
        #1;
        o_gate_wr_en = gate;
        o_id_rd_en = id;
    endtask
    task automatic init();
        set_ctl(1'b1, 1'b0);
        wr(rmc_pkg::OFF_PWR_SAVE, 8'h80);
        wr(rmc_pkg::OFF_CLK_MANUAL, 8'h41);
        wr(rmc_pkg::OFF_CLK_GATE, 8'h41);
    endtask
    // The identifier draws power, so read enable is held only across the four reads.
    task automatic read_id(output logic [31:0] w);
        logic [7:0] b;
        set_ctl(o_gate_wr_en, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            rd(6'(rmc_pkg::OFF_ID_BYTE0 + k), b);
            w[k*8 +: 8] = b;
        end
        set_ctl(o_gate_wr_en, 1'b0);
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the configuration register bank, random data from a fixed seed.
// Assumes the host model in rmc_host_model.sv and the default settle step of the bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [29:0] part_id = 30'h0;
    logic synth_manual = 1'b0;
    logic use_lock_pin = 1'b0;
    logic synth_start = 1'b0;
    logic pll_lock = 1'b0;
    logic wr_stb, rd_stb, gate_en, id_en, power_save, carrier_override, id_powered, synth_locked;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, clk_manual, clk_gate, settle_count;
    logic [31:0] seed = 32'h24ed43fd;
    logic [5:0] offs [5] = '{6'h2e, 6'h2f, 6'h32, 6'h33, 6'h38};
    logic [7:0] rsts [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64};
    int failures = 0;
    int compares = 0;
    always #5 i_clk = ~i_clk;
    rmc_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb),
        .o_addr(addr), .o_wdata(wdata), .o_gate_wr_en(gate_en), .o_id_rd_en(id_en));
    rmc_regs dut (.i_clk(i_clk), .i_srst(i_srst), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .i_addr(addr),
        .i_wdata(wdata), .i_gate_wr_en(gate_en), .i_id_rd_en(id_en), .i_part_id(part_id),
        .i_synth_manual(synth_manual), .i_use_lock_pin(use_lock_pin), .i_synth_start(synth_start),
        .i_pll_lock(pll_lock), .o_rdata(rdata), .o_power_save(power_save),
        .o_carrier_override(carrier_override), .o_clk_manual(clk_manual), .o_clk_gate(clk_gate),
        .o_settle_count(settle_count), .o_id_powered(id_powered), .o_synth_locked(synth_locked));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] id_byte(input logic [29:0] id, input int k);
        logic [31:0] w;
        w = {2'b00, id};
        return w[k*8 +: 8];
    endfunction
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] b;
        logic [5:0] a;
        logic [31:0] w;
        logic exp_ps, exp_co;
        int cnt;
        // The second pass resets in mid-run, so the clock registers must be loaded again.
        for (int r = 0; r < 2; r++)
        begin
            i_srst = 1'b1;
            tick(2);
            i_srst = 1'b0;
            for (int k = 0; k < 5; k++)
            begin
                host.rd(offs[k], b);
                check_byte(b, rsts[k]);
            end
            host.init();
            check_bit(power_save, 1'b1);
            check_byte(clk_manual, 8'h41);
            check_byte(clk_gate, 8'h41);
        end
        exp_ps = 1'b1;
        exp_co = 1'b0;
        for (int n = 0; n < 24; n++)
        begin
            seed = xs(seed);
            host.set_ctl(seed[0], 1'b0);
            a = seed[1] ? rmc_pkg::OFF_CARRIER_OVR : rmc_pkg::OFF_PWR_SAVE;
            host.wr(a, seed[15:8]);
            if (seed[0] && seed[1])
                exp_co = seed[15];
            if (seed[0] && !seed[1])
                exp_ps = seed[15];
            host.rd(a, b);
            check_bit(power_save, exp_ps);
            check_bit(carrier_override, exp_co);
            check_byte(b, {seed[1] ? exp_co : exp_ps, 7'h00});
            host.wr(rmc_pkg::OFF_SETTLE_CNT, seed[23:16]);
            host.rd(rmc_pkg::OFF_SETTLE_CNT, b);
            check_byte(b, seed[23:16]);
        end
        seed = xs(seed);
        part_id = seed[29:0];
        for (int k = 0; k < 4; k++)
        begin
            host.wr(6'(rmc_pkg::OFF_ID_BYTE0 + k), 8'hff);
            host.rd(6'(rmc_pkg::OFF_ID_BYTE0 + k), b);
            check_byte(b, 8'h00);
        end
        host.set_ctl(gate_en, 1'b1);
        tick(1);
        check_bit(id_powered, 1'b1);
        host.read_id(w);
        for (int k = 0; k < 4; k++)
            check_byte(w[k*8 +: 8], id_byte(part_id, k));
        host.rd(6'h10, b);
        check_byte(b, 8'h00);
        check_bit(id_powered, 1'b0);
        for (int n = 0; n < 3; n++)
        begin
            host.wr(rmc_pkg::OFF_SETTLE_CNT, 8'(n));
            tick(1);
            synth_start = 1'b1;
            tick(1);
            synth_start = 1'b0;
            cnt = 0;
            while (synth_locked !== 1'b1 && cnt < 1000)
            begin
                tick(1);
                cnt++;
            end
            if (cnt >= 1000)
            begin
                failures++;
                break;
            end
            check_bit(cnt >= n * rmc_pkg::SETTLE_STEP_CYCLES - 2 && cnt <= n * rmc_pkg::SETTLE_STEP_CYCLES + 5, 1'b1);
        end
        // Manual mode and lock-pin mode both hand the synchronised pin straight through.
        for (int m = 0; m < 2; m++)
        begin
            synth_manual = (m == 0);
            use_lock_pin = (m == 1);
            pll_lock = 1'b1;
            tick(6);
            check_bit(synth_locked, 1'b1);
            pll_lock = 1'b0;
            tick(6);
            check_bit(synth_locked, 1'b0);
        end
        results();
    end
endmodule
`default_nettype wire
